// *** cgc_gate_ctl.sv ***
// counter gate control: 16-bit counter, gate logic, apb registers, interrupt
`timescale 1ns/1ps

module cgc_gate_ctl
    import cgc_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire cgc_pkg::cgc_apb_req_t apbReq,
    output cgc_pkg::cgc_apb_rsp_t apbRsp,
    input  wire logic             gateInputPin,
    input  wire logic             eightBitTimerTick,
    input  wire logic             counterTick,
    output logic                  irq,
    output logic                  counterCountEn,
    output logic [COUNT_WIDTH-1:0] counterValue
);
    import cgc_pkg::*;

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    initial begin
        if (COUNT_WIDTH != 16) $error("counter is split into exactly two bytes");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]             gateCtl_ff;       // writable gate control bits
    logic [7:0]             counterCtl_ff;    // counter control register
    logic [7:0]             irqFlags_ff;      // sticky event flags
    logic [7:0]             irqEn_ff;         // interrupt mask
    logic [COUNT_WIDTH-1:0] count_ff;         // the counter itself
    logic [7:0]             eightBitTimer_ff; // internal 8-bit timer
    logic                   ovfPulse_ff;      // wrap pulse towards the gate
    logic                   toggle_ff;        // gate toggle flip-flop
    logic                   gateSyncPrev_ff;  // previous synchronised gate
    logic                   gateValPrev_ff;   // previous status level
    cgc_sp_state_t          spState_ff;       // single-pulse sequencer
    cgc_sp_state_t          nxt_spState;
    logic [31:0]            rdData_ff;        // registered read data

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    wire logic       runOn      = counterCtl_ff[CC_RUN_BIT];
    wire logic       gateEnable = gateCtl_ff[GC_ENABLE_BIT];
    wire logic       gatePol    = gateCtl_ff[GC_POLARITY_BIT];
    wire logic       toggleMode = gateCtl_ff[GC_TOGGLE_BIT];
    wire logic       spMode     = gateCtl_ff[GC_SPM_BIT];
    wire logic       goDone     = gateCtl_ff[GC_GODONE_BIT];
    wire logic [1:0] srcSel     = gateCtl_ff[GC_SRC_LSB +: 2];

    // ------------------------------------------------------------------
    // gate source selection and synchronisation
    // ------------------------------------------------------------------
    logic gateSync;     // selected source on sys_clk
    wire logic gateRaw =
        (srcSel == SRC_PIN)       ? gateInputPin :
        (srcSel == SRC_TIMER_OVF) ? ovfPulse_ff  :
                                    1'b0;

    // all later edge logic sees only the synchronised copy
    cgc_sync #(
        .STAGES (SYNC_STAGES)
    ) u_gate_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .asyncIn (gateRaw),
        .syncOut (gateSync)
    );

    // polarity folds the active level to high so edges mean the same thing
    wire logic gatePolar  = gatePol ? gateSync : ~gateSync;
    wire logic polarPrev  = gatePol ? gateSyncPrev_ff : ~gateSyncPrev_ff;
    wire logic polarRise  = gatePolar & ~polarPrev;
    // toggle path replaces the level by the flop
    wire logic toggledLvl = toggleMode ? toggle_ff : gatePolar;
    wire logic toggledPrv;
    logic      toggledPrev_ff;
    assign toggledPrv = toggledPrev_ff;
    wire logic stageRise  = toggledLvl & ~toggledPrv;
    wire logic stageFall  = ~toggledLvl & toggledPrv;

    // ------------------------------------------------------------------
    // single-pulse sequencer
    // ------------------------------------------------------------------
    // armed waits for the next incrementing edge, open lasts until the
    // trailing edge; any other gate activity is shut out
    always_comb begin
        nxt_spState = spState_ff;
        case (spState_ff)
            SP_IDLE: begin
                if (spMode && goDone) begin
                    nxt_spState = stageRise ? SP_OPEN : SP_ARMED;
                end
            end
            SP_ARMED: begin
                if (!spMode || !goDone) begin
                    nxt_spState = SP_IDLE;
                end else if (stageRise) begin
                    nxt_spState = SP_OPEN;
                end
            end
            SP_OPEN: begin
                if (!spMode || stageFall) begin
                    nxt_spState = SP_IDLE;
                end
            end
            default: begin
                nxt_spState = SP_IDLE;
            end
        endcase
    end

    wire logic spDone   = (spState_ff == SP_OPEN) && stageFall;
    wire logic gateLvl  = spMode ? (spState_ff == SP_OPEN)
                                 : toggledLvl;
    // the status follows the gate whatever the enable says
    wire logic gateVal  = gateLvl;
    wire logic gateFall = gateValPrev_ff & ~gateVal;

    // run gates everything; enable off means free counting
    assign counterCountEn = runOn & (gateEnable ? gateLvl : 1'b1);
    wire logic countStep = counterCountEn & counterTick;
    wire logic rollOver  = countStep & (&count_ff);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic apbSetup = apbReq.psel & ~apbReq.penable;
    wire logic apbWr    = apbReq.psel & apbReq.penable & apbReq.pwrite;
    wire logic apbRd    = apbSetup & ~apbReq.pwrite;
    wire logic [7:0] wb = apbReq.pwdata[7:0];
    wire logic hitLow   = apbReq.paddr == ADDR_COUNTER_LOW;
    wire logic hitHigh  = apbReq.paddr == ADDR_COUNTER_HIGH;
    wire logic hitCctl  = apbReq.paddr == ADDR_COUNTER_CTL;
    wire logic hitGctl  = apbReq.paddr == ADDR_GATE_CTL;
    wire logic hitFlags = apbReq.paddr == ADDR_IRQ_FLAGS;
    wire logic hitEn    = apbReq.paddr == ADDR_IRQ_ENABLES;
    wire logic hitAny   = hitLow | hitHigh | hitCctl | hitGctl | hitFlags | hitEn;
    // flags clear on the completing read, one edge after the data was sampled
    wire logic flagsRdDone = apbReq.psel & apbReq.penable & ~apbReq.pwrite & hitFlags;

    wire logic [7:0] gateCtlView;
    assign gateCtlView = {gateCtl_ff[7:3], gateVal, gateCtl_ff[1:0]};

    wire logic [7:0] rdByte =
        hitLow   ? count_ff[7:0]   :
        hitHigh  ? count_ff[15:8]  :
        hitCctl  ? counterCtl_ff   :
        hitGctl  ? gateCtlView     :
        hitFlags ? irqFlags_ff     :
        hitEn    ? irqEn_ff        :
                   8'h00;

    // zero wait states: pready is high in every access phase
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~hitAny;
    assign apbRsp.prdata  = rdData_ff;

    // ------------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= 32'h0000_0000;
        end else if (clkEn && apbRd) begin
            rdData_ff <= {24'h00_0000, rdByte};
        end
    end

    // ------------------------------------------------------------------
    // gate control register: go/done set by software, cleared by hardware
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gateCtl_ff <= GATE_CTL_RESET;
        end else if (clkEn) begin
            if (apbWr && hitGctl) begin
                // the status position holds no storage
                gateCtl_ff <= {wb[7:4], wb[3] & ~spDone, 1'b0, wb[1:0]};
            end else if (spDone || !spMode) begin
                gateCtl_ff[GC_GODONE_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // counter control and interrupt enables
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            counterCtl_ff <= COUNTER_CTL_RESET;
            irqEn_ff      <= IRQ_RESET;
        end else if (clkEn) begin
            if (apbWr && hitCctl) begin
                counterCtl_ff <= {wb[7:2], 1'b0, wb[0]};
            end
            if (apbWr && hitEn) begin
                irqEn_ff <= wb;
            end
        end
    end

    // ------------------------------------------------------------------
    // sticky flags: a new event beats the clear by read
    // ------------------------------------------------------------------
    logic [7:0] setMask;
    always_comb begin
        setMask               = 8'h00;
        setMask[IRQ_GATE_BIT] = gateFall;
        setMask[IRQ_ROLL_BIT] = rollOver;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqFlags_ff <= IRQ_RESET;
        end else if (clkEn) begin
            irqFlags_ff <= (flagsRdDone ? 8'h00 : irqFlags_ff) | setMask;
        end
    end

    assign irq = |(irqFlags_ff & irqEn_ff);

    // ------------------------------------------------------------------
    // 16-bit counter with byte writes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (clkEn) begin
            if (apbWr && hitLow) begin
                count_ff[7:0] <= wb;
            end else if (apbWr && hitHigh) begin
                count_ff[15:8] <= wb;
            end else if (countStep) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    assign counterValue = count_ff;

    // ------------------------------------------------------------------
    // 8-bit timer and its wrap pulse
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eightBitTimer_ff <= 8'h00;
            ovfPulse_ff      <= 1'b0;
        end else if (clkEn) begin
            ovfPulse_ff <= eightBitTimerTick && (eightBitTimer_ff == 8'hFF);
            if (eightBitTimerTick) begin
                eightBitTimer_ff <= eightBitTimer_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // toggle flop: held clear when toggle mode or run is off
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            toggle_ff <= 1'b0;
        end else if (clkEn) begin
            if (!toggleMode || !runOn) begin
                toggle_ff <= 1'b0;
            end else if (polarRise) begin
                toggle_ff <= ~toggle_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // edge history and sequencer state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gateSyncPrev_ff <= 1'b0;
            toggledPrev_ff  <= 1'b0;
            gateValPrev_ff  <= 1'b0;
            spState_ff      <= SP_IDLE;
        end else if (clkEn) begin
            gateSyncPrev_ff <= gateSync;
            toggledPrev_ff  <= toggledLvl;
            gateValPrev_ff  <= gateVal;
            spState_ff      <= nxt_spState;
        end
    end
endmodule // cgc_gate_ctl

// *** cgc_gate_ctl_props.sv ***
// concurrent checks on the counter gate control ports
`timescale 1ns/1ps
module cgc_gate_ctl_props #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   clkEn,
    input wire cgc_pkg::cgc_apb_req_t  apbReq,
    input wire cgc_pkg::cgc_apb_rsp_t  apbRsp,
    input wire logic                   gateInputPin,
    input wire logic                   counterTick,
    input wire logic                   irq,
    input wire logic                   counterCountEn,
    input wire logic [COUNT_WIDTH-1:0] counterValue
);
    import cgc_pkg::*;
    // ------------------------------------------------------------------
    // shadow control bits from completed writes
    // ------------------------------------------------------------------
    logic       wrAcc;     // completed write transfer
    logic       cntWr;     // write into a counter byte
    logic       plainPin;  // pin source, no toggle, no single pulse
    logic       runSh_ff;  // copy of counter_run
    logic [7:0] gcSh_ff;   // copy of gate_control
    logic [7:0] ieSh_ff;   // copy of peripheral_irq_enables
    logic [1:0] age_ff;    // edges since config write or freeze
    logic       nxt_run;
    logic [7:0] nxt_gc;
    logic [7:0] nxt_ie;
    logic [1:0] nxt_age;
    logic       cfgWr;
    assign wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite & apbRsp.pready & clkEn;
    assign cntWr = wrAcc & (apbReq.paddr == ADDR_COUNTER_LOW | apbReq.paddr == ADDR_COUNTER_HIGH);
    assign cfgWr = wrAcc & (apbReq.paddr == ADDR_GATE_CTL | apbReq.paddr == ADDR_COUNTER_CTL);
    assign nxt_run = (wrAcc && apbReq.paddr == ADDR_COUNTER_CTL) ? apbReq.pwdata[0] : runSh_ff;
    assign nxt_gc = (wrAcc && apbReq.paddr == ADDR_GATE_CTL) ? apbReq.pwdata[7:0] : gcSh_ff;
    assign nxt_ie = (wrAcc && apbReq.paddr == ADDR_IRQ_ENABLES) ? apbReq.pwdata[7:0] : ieSh_ff;
    // a freeze stalls the synchroniser: restart the age
    assign nxt_age = (cfgWr || !clkEn) ? 2'h0 : ((age_ff == 2'h3) ? age_ff : age_ff + 2'h1);
    assign plainPin = runSh_ff & gcSh_ff[7] & (gcSh_ff[5:4] == 2'h0) & (gcSh_ff[1:0] == 2'h0);
    // shadows follow the design's reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            runSh_ff <= 1'b0;
            gcSh_ff  <= 8'h00;
            ieSh_ff  <= 8'h00;
            age_ff   <= 2'h0;
        end else begin
            runSh_ff <= nxt_run;
            gcSh_ff  <= nxt_gc;
            ieSh_ff  <= nxt_ie;
            age_ff   <= nxt_age;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RUN_OFF: assert property (!runSh_ff |-> !counterCountEn)
        else $error("count enable high while stopped");
    AST_FREE_RUN: assert property (runSh_ff && !gcSh_ff[7] |-> counterCountEn)
        else $error("count enable low with gating off");
    AST_POLARITY: assert property (plainPin && age_ff == 2'h3 |->
        counterCountEn == (gcSh_ff[6] ~^ $past(gateInputPin, 2)))
        else $error("gate level off the synchronised pin");
    AST_RESERVED: assert property (runSh_ff && gcSh_ff[7] && gcSh_ff[6] && gcSh_ff[1]
        && gcSh_ff[5:4] == 2'h0 && age_ff == 2'h3 |-> !counterCountEn)
        else $error("reserved source gave an active gate");
    AST_COUNT_UP: assert property (clkEn && counterTick && counterCountEn && !cntWr
        |=> counterValue == COUNT_WIDTH'($past(counterValue) + 1))
        else $error("counter did not advance by one");
    AST_COUNT_HOLD: assert property (!(clkEn && counterTick && counterCountEn) && !cntWr
        |=> $stable(counterValue))
        else $error("counter moved without an enabled tick");
    AST_IRQ_MASK: assert property (!ieSh_ff[7] && !ieSh_ff[0] |-> !irq)
        else $error("interrupt raised with all sources masked");
    AST_PRDATA_BYTE: assert property (apbRsp.prdata[31:8] == 24'h0)
        else $error("read data above byte lane not zero");
endmodule // cgc_gate_ctl_props

// *** cgc_gate_src.sv ***
// far-side model: external gate pin and eight-bit timer tick source
`timescale 1ns/1ps
module cgc_gate_src (
    input  wire logic sys_clk,
    output logic      gateInputPin,
    output logic      eightBitTimerTick
);
    // lines idle low
    initial begin
        gateInputPin      = 1'b0;
        eightBitTimerTick = 1'b0;
    end
    // pin moves just after a rising edge
    task automatic setPin(input logic v);
        @(posedge sys_clk);
        gateInputPin <= v;
    endtask
    // n ticks, one per gap+1 cycles
    task automatic ticks(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            eightBitTimerTick <= 1'b1;
            repeat (gap) begin
                @(posedge sys_clk);
                eightBitTimerTick <= 1'b0;
            end
        end
        @(posedge sys_clk);
        eightBitTimerTick <= 1'b0;
    endtask
endmodule // cgc_gate_src

// *** cgc_pkg.sv ***
// package of constants and carrier types for the counter gate control block
package cgc_pkg;

    // ------------------------------------------------------------------
    // register byte addresses (apb, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNTER_LOW  = 8'h00;   // counter_low_byte
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h04;   // counter_high_byte
    localparam logic [7:0] ADDR_COUNTER_CTL  = 8'h08;   // counter_control
    localparam logic [7:0] ADDR_GATE_CTL     = 8'h0C;   // gate_control
    localparam logic [7:0] ADDR_IRQ_FLAGS    = 8'h10;   // peripheral_irq_flags
    localparam logic [7:0] ADDR_IRQ_ENABLES  = 8'h14;   // peripheral_irq_enables

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int GC_ENABLE_BIT   = 7;     // gate_enable_ctl
    localparam int GC_POLARITY_BIT = 6;     // gate_polarity
    localparam int GC_TOGGLE_BIT   = 5;     // gate_toggle_mode
    localparam int GC_SPM_BIT      = 4;     // gate_single_pulse_mode
    localparam int GC_GODONE_BIT   = 3;     // pulse_acquire_go_done
    localparam int GC_VALUE_BIT    = 2;     // gate_level_value
    localparam int GC_SRC_LSB      = 0;     // gate_source_sel (2 bits)
    localparam int CC_RUN_BIT      = 0;     // counter_run
    localparam int IRQ_GATE_BIT    = 7;     // gate event flag / enable
    localparam int IRQ_ROLL_BIT    = 0;     // counter rollover flag / enable

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] GATE_CTL_RESET    = 8'h00;
    localparam logic [7:0] COUNTER_CTL_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET         = 8'h00;
    localparam logic [1:0] SRC_PIN           = 2'h0;
    localparam logic [1:0] SRC_TIMER_OVF     = 2'h1;
    localparam int         SYNC_STAGES       = 2;

    // single-pulse acquisition states
    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ARMED,
        SP_OPEN
    } cgc_sp_state_t;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cgc_apb_req_t;

    // apb answer carrier
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cgc_apb_rsp_t;

endpackage

// *** cgc_sync.sv ***
// two flip-flop level synchroniser with clock enable
`timescale 1ns/1ps
module cgc_sync #(
    parameter int STAGES = 2
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    import cgc_pkg::*;

    logic [STAGES-1:0] chain_ff;   // first stage feeds only the second

    initial begin
        if (STAGES < 2) $error("cgc_sync needs at least two stages");
    end

    // ------------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chain_ff <= '0;
        end else if (clkEn) begin
            chain_ff <= {chain_ff[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain_ff[STAGES-1];
endmodule // cgc_sync

// *** tb_counter_gate_control.sv ***
// self-checking bench for the counter gate control block
`timescale 1ns/1ps
module tb_counter_gate_control;
    import cgc_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic         sys_clk;
    logic         rst;
    logic         clkEn;
    logic         counterTick;
    cgc_apb_req_t apbReq;
    cgc_apb_rsp_t apbRsp;
    logic         gateInputPin;
    logic         eightBitTimerTick;
    logic         irq;
    logic         counterCountEn;
    logic [15:0]  counterValue;
    logic [31:0]  rdVal;          // data of the last read
    logic         lastErr;        // slave error of last transfer
    int           failCount = 0;
    int           totalChecks = 0;
    logic [7:0]   addrs [6] = '{ADDR_COUNTER_LOW, ADDR_COUNTER_HIGH, ADDR_COUNTER_CTL,
                                ADDR_GATE_CTL, ADDR_IRQ_FLAGS, ADDR_IRQ_ENABLES};
    cgc_gate_ctl #(.COUNT_WIDTH(16)) dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .apbReq(apbReq), .apbRsp(apbRsp), .gateInputPin(gateInputPin),
        .eightBitTimerTick(eightBitTimerTick), .counterTick(counterTick), .irq(irq),
        .counterCountEn(counterCountEn), .counterValue(counterValue));
    cgc_gate_src src_u (.sys_clk(sys_clk), .gateInputPin(gateInputPin),
        .eightBitTimerTick(eightBitTimerTick));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // random ticks keep the counter moving
    always @(posedge sys_clk) counterTick <= 1'($urandom_range(0, 1));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        @(posedge sys_clk);
        while (apbRsp.pready !== 1'b1) @(posedge sys_clk);
        rdVal = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rdVal & m, exp);
    endtask
    // n edges, then mid-cycle where outputs settle
    task automatic waitC(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic chkEn(input string what, input logic exp);
        check(what, {31'h0, counterCountEn}, {31'h0, exp});
    endtask
    function automatic logic [31:0] gc(input logic en, pol, tm, spm, go, input logic [1:0] s);
        return {24'h0, en, pol, tm, spm, go, 1'b0, s};
    endfunction
    task automatic stopTest();
        if (failCount == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic        e;
        rst = 1'b1;
        clkEn = 1'b1;
        counterTick = 1'b0;
        apbReq = '0;
        void'($urandom(30498));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (addrs[i]) rdChk("reset", addrs[i], 32'hFFFF_FFFB, 32'h0);
        rdChk("unmapped", 8'h18, 32'hFFFF_FFFF, 32'h0);
        check("slverr", {31'h0, lastErr}, 32'h1);
        repeat (4) begin
            v = $urandom;
            xfer(1'b1, ADDR_COUNTER_LOW, {24'h0, v[7:0]});
            xfer(1'b1, ADDR_COUNTER_HIGH, {24'h0, v[15:8]});
            rdChk("cnt_lo", ADDR_COUNTER_LOW, 32'hFF, {24'h0, v[7:0]});
            rdChk("cnt_hi", ADDR_COUNTER_HIGH, 32'hFF, {24'h0, v[15:8]});
        end
        xfer(1'b1, ADDR_COUNTER_CTL, 32'h1);
        waitC(1);
        chkEn("free_run", 1'b1);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        waitC(1);
        v = {16'h0, counterValue};
        waitC(3);
        check("frozen", {16'h0, counterValue}, v);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        // each enable, polarity, pin level; status write ignored
        for (int k = 0; k < 8; k++) begin
            src_u.setPin(k[0]);
            v = gc(k[2], k[1], 0, 0, 0, SRC_PIN);
            xfer(1'b1, ADDR_GATE_CTL, v | 32'h4);
            waitC(3);
            e = k[1] ~^ k[0];
            chkEn("count_en", k[2] ? e : 1'b1);
            rdChk("gate_ctl", ADDR_GATE_CTL, 32'hFF, v | {29'h0, e, 2'h0});
        end
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, ADDR_GATE_CTL, gc(1, k[0], 0, 0, 0, {1'b1, k[1]}));
            waitC(4);
            chkEn("reserved", !k[0]);
        end
        // timer wrap pulses through the toggle flop
        src_u.setPin(1'b0);
        xfer(1'b1, ADDR_GATE_CTL, gc(1, 1, 1, 0, 0, SRC_TIMER_OVF));
        src_u.ticks(255, 1);
        waitC(4);
        chkEn("ovf_255", 1'b0);
        for (int k = 1; k <= 3; k++) begin
            src_u.ticks((k == 1) ? 1 : 256, 0);
            waitC(4);
            chkEn("ovf_toggle", k[0]);
        end
        xfer(1'b1, ADDR_GATE_CTL, gc(1, 1, 0, 0, 0, SRC_TIMER_OVF));
        waitC(4);
        chkEn("toggle_off", 1'b0);
        // gate event flag with gating off: enabled, then masked
        xfer(1'b1, ADDR_GATE_CTL, gc(0, 1, 0, 0, 0, SRC_PIN));
        for (int k = 1; k >= 0; k--) begin
            xfer(1'b1, ADDR_IRQ_ENABLES, {24'h0, k[0], 7'h0});
            src_u.setPin(1'b1);
            waitC(4);
            xfer(1'b0, ADDR_IRQ_FLAGS, 32'h0);
            src_u.setPin(1'b0);
            waitC(4);
            check("irq", {31'h0, irq}, {31'h0, k[0]});
            rdChk("flag", ADDR_IRQ_FLAGS, 32'h80, 32'h80);
            rdChk("flag_clr", ADDR_IRQ_FLAGS, 32'h80, 32'h0);
            waitC(0);
            check("irq_clr", {31'h0, irq}, 32'h0);
        end
        // single pulse: idle, armed, open, closed, no second window
        xfer(1'b1, ADDR_GATE_CTL, gc(1, 1, 0, 1, 0, SRC_PIN));
        waitC(4);
        chkEn("sp_idle", 1'b0);
        xfer(1'b1, ADDR_GATE_CTL, gc(1, 1, 0, 1, 1, SRC_PIN));
        rdChk("sp_armed", ADDR_GATE_CTL, 32'h8, 32'h8);
        for (int k = 0; k < 3; k++) begin
            src_u.setPin(k != 1);
            waitC(4);
            chkEn("sp_gate", k == 0);
            rdChk("sp_go", ADDR_GATE_CTL, 32'h8, {28'h0, k == 0, 3'h0});
        end
        xfer(1'b1, ADDR_COUNTER_CTL, 32'h0);
        waitC(1);
        chkEn("run_off", 1'b0);
        // pin low first, so the synchroniser restart makes no false gate fall
        src_u.setPin(1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (addrs[i]) rdChk("rerst", addrs[i], 32'hFFFF_FFFB, 32'h0);
        stopTest();
    end
    // watchdog far past the scenarios
    initial begin
        repeat (30000) @(posedge sys_clk);
        failCount++;
        stopTest();
    end
endmodule // tb_counter_gate_control

bind cgc_gate_ctl cgc_gate_ctl_props #(.COUNT_WIDTH(COUNT_WIDTH)) props_u (.sys_clk(sys_clk),
    .rst(rst), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp), .gateInputPin(gateInputPin),
    .counterTick(counterTick), .irq(irq),
    .counterCountEn(counterCountEn), .counterValue(counterValue));
